// *** rtl/dcs_map.svh ***
// Purpose: offsets, field positions and reset values of the DMA sequencer
// Assumes: included by bare name
// Notes: offsets are the decoded register index
`ifndef DCS_MAP_SVH
`define DCS_MAP_SVH
`define DCS_OFF_STATUS 4'h8
`define DCS_OFF_COMMAND_WR 4'h8
`define DCS_OFF_REQUEST 4'h9
`define DCS_OFF_COMMAND_RD 4'ha
`define DCS_OFF_MASK_ONE 4'ha
`define DCS_OFF_MODE 4'hb
`define DCS_OFF_POINTER 4'hc
`define DCS_OFF_MASTER_CLR 4'hd
`define DCS_OFF_CLR_MASK 4'he
`define DCS_OFF_MASK_ALL 4'hf
`define DCS_CMD_DISABLE_BIT 2
`define DCS_SETCLR_BIT 2
`define DCS_MODE_LSB 2
`define DCS_MASK_RESET 4'hf
`define DCS_COMMAND_RESET 8'h00
`define DCS_WAIT_STATES 1
`endif

// *** rtl/dcs_pkg.sv ***
// Purpose: types shared by the DMA channel sequencer
// Assumes: nothing
// Notes: mode layout is xfer[1:0], autoinit, direction, tmode[1:0]
package dcs_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_S0 = 3'b001, ST_S1 = 3'b010, ST_S2 = 3'b011,
    ST_S3 = 3'b100, ST_S4 = 3'b101, ST_CASC = 3'b110, ST_RELEASE = 3'b111
  } dcs_state_t;
  typedef enum logic [1:0] {
    XF_VERIFY = 2'b00, XF_WRITE = 2'b01, XF_READ = 2'b10, XF_ILLEGAL = 2'b11
  } dcs_xfer_t;
  typedef enum logic [1:0] {
    TM_DEMAND = 2'b00, TM_SINGLE = 2'b01, TM_BLOCK = 2'b10, TM_CASCADE = 2'b11
  } dcs_tmode_t;
  typedef struct packed {
    dcs_tmode_t tmode;
    logic addressDirectionBit;
    logic autoInit;
    dcs_xfer_t xfer;
  } dcs_mode_t;
  typedef struct packed {
    logic [15:0] baseAddr;
    logic [15:0] curAddr;
    logic [15:0] baseCount;
    logic [15:0] curCount;
    dcs_mode_t mode;
  } dcs_chan_t;
  typedef struct packed {
    logic memReadCommand;
    logic memWriteCommand;
    logic ioReadCommand;
    logic ioWriteCommand;
  } dcs_cmd_t;
endpackage

// *** rtl/dma_channel_sequencer.sv ***
// Purpose: four-channel DMA sequencer with CPU programming port
// Assumes: one clock; strobes, requests, ready and hold ack are pins
// Notes: all outputs registered; acknowledges are active high
//
// What this block does
// - In idle, sample every request and the select/hold-ack pair each cycle.
// - CPU register access wins over a pending peripheral request.
// - Program condition whenever hold ack is low and select is high.
// - Byte controller decodes addr[3:0]; word controller addr[4:1], ignores bit 0.
// - Byte pointer picks low/high byte; reset, master clear, commands control it.
// - Special commands decoded from address, select and strobe, data ignored.
// - Unmasked request or software request raises hold request.
// - Wait for hold ack, then S0 resolves priority and raises acknowledge.
// - Read transfer: address in S1, memory read in S2, I/O write in S3.
// - Stay in S3 until wait counter expires and ready is high.
// - On ready go to S4 and drop memory read and I/O write.
// - Demand follow-on transfers start in S2; S1 only when upper address changes.
// - Each channel programmable to single, block, demand or cascade.
// - Single mode: one transfer, drop hold, re-request after hold ack falls.
// - After each transfer decrement count, step address per direction bit.
// - Count wrap from 0000h sets status bit and pulses terminal count.
// - At terminal count autoinit reloads, else channel mask bit is set.
// - Block mode runs without bus release until terminal count.
// - Demand mode runs until terminal count or request drops.
// - Cascade: no address or commands, only hold ack and active request watched.
// - Write transfer asserts memory write and I/O read together.
// - Verify transfer sequences normally without commands, ignoring ready.
`include "dcs_map.svh"
`timescale 1ns/1ps
`default_nettype none
module dma_channel_sequencer
  import dcs_pkg::*;
#(
  parameter bit WORD_CONTROLLER = 1'b0,
  parameter int WAIT_STATES = `DCS_WAIT_STATES
)(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] periphRequest,
  input wire logic holdAcknowledge,
  input wire logic chipSelect,
  input wire logic ioReadStrobe,
  input wire logic ioWriteStrobe,
  input wire logic ioChannelReady,
  input wire logic [4:0] regAddr,
  input wire logic [7:0] dataIn,
  output dcs_pkg::dcs_cmd_t command,
  output logic holdRequest,
  output logic [3:0] channelAcknowledge,
  output logic [15:0] addrOut,
  output logic addrStrobe,
  output logic terminalCountOut,
  output logic [7:0] dataOut,
  output logic dataOutEn
);
  import dcs_pkg::*;

  // --------------------------------------------------------------
  // Reset and input synchronisers
  // --------------------------------------------------------------
  logic [1:0] rstSync;
  logic rstn;
  logic [3:0] reqMeta, reqS;
  logic [4:0] addrMeta, addrS;
  logic [7:0] dataMeta, dataS;
  logic [3:0] ctlMeta, ctlS;
  logic iorPrev, iowPrev;
  logic holdAckS, iorS, iowS, rdyS;

  assign rstn = rstSync[1];
  assign holdAckS = ctlS[0];
  assign iorS = ctlS[1];
  assign iowS = ctlS[2];
  assign rdyS = ctlS[3];

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rstSync <= 2'h0;
    else
      rstSync <= {rstSync[0], 1'b1};
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reqMeta <= 4'h0;
      reqS <= 4'h0;
      addrMeta <= 5'h00;
      addrS <= 5'h00;
      dataMeta <= 8'h00;
      dataS <= 8'h00;
      ctlMeta <= 4'h0;
      ctlS <= 4'h0;
      iorPrev <= 1'b0;
      iowPrev <= 1'b0;
    end
    else
    begin
      reqMeta <= periphRequest;
      reqS <= reqMeta;
      addrMeta <= regAddr;
      addrS <= addrMeta;
      dataMeta <= dataIn;
      dataS <= dataMeta;
      ctlMeta <= {ioChannelReady, ioWriteStrobe, ioReadStrobe, holdAcknowledge};
      ctlS <= ctlMeta;
      iorPrev <= iorS;
      iowPrev <= iowS;
    end
  end

  // --------------------------------------------------------------
  // Sequencer and register file
  // --------------------------------------------------------------
  dcs_state_t state, next_state;
  dcs_chan_t [3:0] chan, next_chan;
  logic [3:0] mask, next_mask, softReq, next_softReq, tcStatus, next_tcStatus;
  logic [7:0] cmdReg, next_cmdReg;
  logic bytePtr, next_bytePtr;
  logic [1:0] activeCh, next_activeCh;
  logic [7:0] waitCnt, next_waitCnt;
  dcs_cmd_t next_command;
  logic next_holdRequest, next_addrStrobe, next_terminalCountOut, next_dataOutEn;
  logic [3:0] next_channelAcknowledge;
  logic [15:0] next_addrOut;
  logic [7:0] next_dataOut;

  logic [3:0] idx;
  logic [1:0] rch;
  logic programming, iorRise, iowRise;
  logic [3:0] pending;
  logic [1:0] winner;
  logic [15:0] stepAddr;
  logic [15:0] regWord;
  dcs_mode_t am;

  always_comb
  begin
    idx = WORD_CONTROLLER ? addrS[4:1] : addrS[3:0];
    rch = idx[2:1];
    iorRise = iorS & ~iorPrev;
    iowRise = iowS & ~iowPrev;
    programming = chipSelect & ~holdAckS;
    pending = (reqS & ~mask) | softReq;
    winner = pending[0] ? 2'd0 : pending[1] ? 2'd1 : pending[2] ? 2'd2 : 2'd3;
    am = chan[activeCh].mode;
    stepAddr = am.addressDirectionBit ? chan[activeCh].curAddr - 16'h0001
                                      : chan[activeCh].curAddr + 16'h0001;
    regWord = idx[0] ? chan[rch].curCount : chan[rch].curAddr;
    next_state = state;
    next_chan = chan;
    next_mask = mask;
    next_softReq = softReq;
    next_tcStatus = tcStatus;
    next_cmdReg = cmdReg;
    next_bytePtr = bytePtr;
    next_activeCh = activeCh;
    next_waitCnt = waitCnt;
    next_command = '0;
    next_holdRequest = holdRequest;
    next_channelAcknowledge = channelAcknowledge;
    next_addrOut = addrOut;
    next_addrStrobe = 1'b0;
    next_terminalCountOut = 1'b0;
    next_dataOut = dataOut;
    next_dataOutEn = programming & iorS;

    // Register writes and write-side special commands
    if (programming && iowRise)
    begin
      if (!idx[3])
      begin
        if (idx[0])
        begin
          if (bytePtr)
            next_chan[rch].baseCount[15:8] = dataS;
          else
            next_chan[rch].baseCount[7:0] = dataS;
          next_chan[rch].curCount = bytePtr ? {dataS, chan[rch].baseCount[7:0]}
                                            : {chan[rch].baseCount[15:8], dataS};
        end
        else
        begin
          if (bytePtr)
            next_chan[rch].baseAddr[15:8] = dataS;
          else
            next_chan[rch].baseAddr[7:0] = dataS;
          next_chan[rch].curAddr = bytePtr ? {dataS, chan[rch].baseAddr[7:0]}
                                           : {chan[rch].baseAddr[15:8], dataS};
        end
        next_bytePtr = ~bytePtr;
      end
      else
      begin
        case (idx)
          `DCS_OFF_COMMAND_WR: next_cmdReg = dataS;
          `DCS_OFF_REQUEST: next_softReq[dataS[1:0]] = dataS[`DCS_SETCLR_BIT];
          `DCS_OFF_MASK_ONE: next_mask[dataS[1:0]] = dataS[`DCS_SETCLR_BIT];
          `DCS_OFF_MODE: next_chan[dataS[1:0]].mode = dataS[7:`DCS_MODE_LSB];
          `DCS_OFF_POINTER: next_bytePtr = 1'b0;
          `DCS_OFF_MASTER_CLR:
          begin
            next_bytePtr = 1'b0;
            next_cmdReg = `DCS_COMMAND_RESET;
            next_mask = `DCS_MASK_RESET;
            next_softReq = 4'h0;
            next_tcStatus = 4'h0;
          end
          `DCS_OFF_CLR_MASK: next_mask = 4'h0;
          `DCS_OFF_MASK_ALL: next_mask = dataS[3:0];
          default: ;
        endcase
      end
    end

    // Register reads and read-side special commands
    if (programming && iorRise)
    begin
      if (!idx[3])
      begin
        next_dataOut = bytePtr ? regWord[15:8] : regWord[7:0];
        next_bytePtr = ~bytePtr;
      end
      else
      begin
        case (idx)
          `DCS_OFF_STATUS:
          begin
            next_dataOut = {reqS, tcStatus};
            next_tcStatus = 4'h0;
          end
          `DCS_OFF_REQUEST: next_dataOut = {4'h0, softReq};
          `DCS_OFF_COMMAND_RD: next_dataOut = cmdReg;
          `DCS_OFF_MODE: next_dataOut = {chan[rch].mode, 2'h0};
          `DCS_OFF_POINTER: next_bytePtr = 1'b1;
          `DCS_OFF_MASK_ALL: next_dataOut = {4'h0, mask};
          default: next_dataOut = 8'h00;
        endcase
      end
    end

    // Transfer state machine
    case (state)
      ST_IDLE:
      begin
        next_channelAcknowledge = 4'h0;
        if (programming)
          next_holdRequest = 1'b0;
        else if (|pending && !cmdReg[`DCS_CMD_DISABLE_BIT])
        begin
          next_holdRequest = 1'b1;
          if (holdAckS)
            next_state = ST_S0;
        end
        else
          next_holdRequest = 1'b0;
      end
      ST_S0:
      begin
        next_activeCh = winner;
        next_channelAcknowledge = 4'h1 << winner;
        if (chan[winner].mode.tmode == TM_CASCADE)
          next_state = ST_CASC;
        else
          next_state = ST_S1;
      end
      ST_S1:
      begin
        next_addrOut = chan[activeCh].curAddr;
        next_addrStrobe = 1'b1;
        next_state = ST_S2;
      end
      ST_S2:
      begin
        next_addrOut = chan[activeCh].curAddr;
        next_waitCnt = 8'(WAIT_STATES);
        next_state = ST_S3;
      end
      ST_S3:
      begin
        if (waitCnt != 8'h00)
          next_waitCnt = waitCnt - 8'h01;
        else if (rdyS || am.xfer == XF_VERIFY)
        begin
          next_state = ST_S4;
        end
      end
      ST_S4:
      begin
        next_chan[activeCh].curAddr = stepAddr;
        next_chan[activeCh].curCount = chan[activeCh].curCount - 16'h0001;
        if (chan[activeCh].curCount == 16'h0000)
        begin
          next_tcStatus[activeCh] = 1'b1;
          next_terminalCountOut = 1'b1;
          next_softReq[activeCh] = 1'b0;
          if (am.autoInit)
          begin
            next_chan[activeCh].curAddr = chan[activeCh].baseAddr;
            next_chan[activeCh].curCount = chan[activeCh].baseCount;
          end
          else
            next_mask[activeCh] = 1'b1;
          next_holdRequest = 1'b0;
          next_state = ST_RELEASE;
        end
        else if (am.tmode == TM_BLOCK ||
                 (am.tmode == TM_DEMAND && (reqS[activeCh] || softReq[activeCh])))
          next_state = (stepAddr[15:8] != chan[activeCh].curAddr[15:8]) ? ST_S1 : ST_S2;
        else
        begin
          if (am.tmode == TM_SINGLE)
            next_softReq[activeCh] = 1'b0;
          next_holdRequest = 1'b0;
          next_state = ST_RELEASE;
        end
      end
      ST_CASC:
      begin
        if (!reqS[activeCh] || !holdAckS)
        begin
          next_holdRequest = 1'b0;
          next_state = ST_RELEASE;
        end
      end
      ST_RELEASE:
      begin
        next_channelAcknowledge = 4'h0;
        next_holdRequest = 1'b0;
        if (!holdAckS)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase

    // Commands track the state being entered
    if (next_state == ST_S2 || next_state == ST_S3)
    begin
      next_command.memReadCommand = (am.xfer == XF_READ);
      next_command.memWriteCommand = (am.xfer == XF_WRITE);
      next_command.ioReadCommand = (am.xfer == XF_WRITE);
      next_command.ioWriteCommand = (am.xfer == XF_READ) && (next_state == ST_S3);
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= ST_IDLE;
      chan <= '0;
      mask <= `DCS_MASK_RESET;
      softReq <= 4'h0;
      tcStatus <= 4'h0;
      cmdReg <= `DCS_COMMAND_RESET;
      bytePtr <= 1'b0;
      activeCh <= 2'd0;
      waitCnt <= 8'h00;
      command <= '0;
      holdRequest <= 1'b0;
      channelAcknowledge <= 4'h0;
      addrOut <= 16'h0000;
      addrStrobe <= 1'b0;
      terminalCountOut <= 1'b0;
      dataOut <= 8'h00;
      dataOutEn <= 1'b0;
    end
    else
    begin
      state <= next_state;
      chan <= next_chan;
      mask <= next_mask;
      softReq <= next_softReq;
      tcStatus <= next_tcStatus;
      cmdReg <= next_cmdReg;
      bytePtr <= next_bytePtr;
      activeCh <= next_activeCh;
      waitCnt <= next_waitCnt;
      command <= next_command;
      holdRequest <= next_holdRequest;
      channelAcknowledge <= next_channelAcknowledge;
      addrOut <= next_addrOut;
      addrStrobe <= next_addrStrobe;
      terminalCountOut <= next_terminalCountOut;
      dataOut <= next_dataOut;
      dataOutEn <= next_dataOutEn;
    end
  end
endmodule
`default_nettype wire

// *** testbench/dcs_asserts.sv ***
// Purpose: port checks for the DMA sequencer
// Assumes: bound to dma_channel_sequencer
// Notes: one clock domain
`timescale 1ns/1ps
`default_nettype none
module dcs_asserts
  import dcs_pkg::*;
#(
  parameter int WAIT_STATES = 1
)(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ioChannelReady,
  input wire dcs_pkg::dcs_cmd_t command,
  input wire logic holdRequest,
  input wire logic [3:0] channelAcknowledge,
  input wire logic terminalCountOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Length of the current io write
  logic [7:0] ioWrRun;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ioWrRun <= 8'h00;
    else if (!command.ioWriteCommand)
      ioWrRun <= 8'h00;
    else if (ioWrRun != 8'hff)
      ioWrRun <= ioWrRun + 8'h01;
  end
  chk_ack_onehot: assert property ($onehot0(channelAcknowledge))
    else $error("acknowledge not one-hot");
  chk_cmd_has_ack: assert property ((|command) |-> (|channelAcknowledge))
    else $error("command without acknowledge");
  chk_ack_has_hold: assert property ($rose(|channelAcknowledge) |-> holdRequest)
    else $error("acknowledge without hold request");
  chk_read_pair: assert property (command.memReadCommand |->
    !command.memWriteCommand && !command.ioReadCommand)
    else $error("read mixed with write commands");
  chk_write_pair: assert property ($rose(command.memWriteCommand) |->
    command.ioReadCommand)
    else $error("memory write without io read");
  chk_mem_first: assert property ($rose(command.ioWriteCommand) |->
    $past(command.memReadCommand))
    else $error("io write before memory read");
  chk_s3_min: assert property ($rose(command.ioWriteCommand) |=>
    command.ioWriteCommand)
    else $error("no extra wait cycle");
  chk_s3_exit: assert property ((command.ioWriteCommand && ioChannelReady &&
    ioWrRun >= WAIT_STATES)[*3] |=> !command.ioWriteCommand)
    else $error("wait state not left on ready");
  chk_cmd_drop: assert property ($fell(command.memReadCommand) |->
    !command.ioWriteCommand)
    else $error("commands not dropped together");
  chk_tc_pulse: assert property (terminalCountOut |=> !terminalCountOut)
    else $error("terminal count longer than a cycle");
endmodule
bind dma_channel_sequencer dcs_asserts #(.WAIT_STATES(WAIT_STATES)) chk (
  .clk(clk), .resetn(resetn), .ioChannelReady(ioChannelReady), .command(command),
  .holdRequest(holdRequest), .channelAcknowledge(channelAcknowledge),
  .terminalCountOut(terminalCountOut));
`default_nettype wire

// *** testbench/dcs_partner.sv ***
// Purpose: bus owner granting hold and ready line
// Assumes: slow selects late grant and late ready
// Notes: ready idles high except while slow with hold acknowledged
`timescale 1ns/1ps
`default_nettype none
module dcs_partner (
  input wire logic clk,
  input wire logic resetn,
  input wire logic holdRequest,
  input wire dcs_pkg::dcs_cmd_t command,
  input wire logic slow,
  output logic holdAcknowledge,
  output logic ioChannelReady
);
  import dcs_pkg::*;
  logic [3:0] hcnt;
  logic [3:0] rcnt;
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      holdAcknowledge <= 1'b0;
      ioChannelReady <= 1'b1;
      hcnt <= 4'h0;
      rcnt <= 4'h0;
    end
    else
    begin
      // Grant or withdraw the bus after a delay
      hcnt <= (holdRequest != holdAcknowledge) ? hcnt + 4'h1 : 4'h0;
      if (holdRequest != holdAcknowledge && hcnt >= (slow ? 4'h6 : 4'h1))
        holdAcknowledge <= holdRequest;
      // Stretch each command when slow
      rcnt <= (|command) ? rcnt + 4'h1 : 4'h0;
      ioChannelReady <= !slow || !holdAcknowledge || ((|command) && rcnt >= 4'h4);
    end
  end
endmodule
`default_nettype wire

// *** testbench/dma_channel_sequencer_bench.sv ***
// Purpose: self-checking bench for the DMA sequencer
// Assumes: byte controller, default wait states
// Notes: reads and address strobes checked from queues
`timescale 1ns/1ps
`default_nettype none
module dma_channel_sequencer_bench;
  import dcs_pkg::*;
  logic clk, resetn, holdAcknowledge, chipSelect, ioReadStrobe, ioWriteStrobe;
  logic ioChannelReady, holdRequest, addrStrobe, terminalCountOut, dataOutEn, slow, lastEn;
  logic [3:0] periphRequest, channelAcknowledge;
  logic [4:0] regAddr;
  logic [7:0] dataIn, dataOut;
  logic [15:0] addrOut, e, a;
  dcs_cmd_t command;
  int fail_count, comparisons, tcSeen, cascCmd;
  logic [15:0] addrQ[$];
  logic [15:0] rdQ[$];
  dma_channel_sequencer uut (.clk(clk), .resetn(resetn), .periphRequest(periphRequest),
    .holdAcknowledge(holdAcknowledge), .chipSelect(chipSelect), .ioReadStrobe(ioReadStrobe),
    .ioWriteStrobe(ioWriteStrobe), .ioChannelReady(ioChannelReady), .regAddr(regAddr),
    .dataIn(dataIn), .command(command), .holdRequest(holdRequest),
    .channelAcknowledge(channelAcknowledge), .addrOut(addrOut), .addrStrobe(addrStrobe),
    .terminalCountOut(terminalCountOut), .dataOut(dataOut), .dataOutEn(dataOutEn));
  dcs_partner partner (.clk(clk), .resetn(resetn), .holdRequest(holdRequest),
    .command(command), .slow(slow), .holdAcknowledge(holdAcknowledge),
    .ioChannelReady(ioChannelReady));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Monitor
  always @(posedge clk)
  begin
    lastEn <= dataOutEn;
    if (addrStrobe)
    begin
      e = (addrQ.size() > 0) ? addrQ.pop_front() : 16'hxxxx;
      check("address", addrOut, e);
    end
    if (lastEn && !dataOutEn)
    begin
      e = rdQ.pop_front();
      check("read data", {8'h00, dataOut & e[15:8]}, {8'h00, e[7:0]});
    end
    if (terminalCountOut)
      tcSeen++;
    if (channelAcknowledge[3] && ((|command) || addrStrobe))
      cascCmd++;
  end
  // Bus tasks
  task automatic cyc(input bit wr, input logic [3:0] idx, input logic [7:0] d);
    @(posedge clk);
    regAddr <= {1'($urandom), idx};
    dataIn <= d;
    chipSelect <= 1'b1;
    ioWriteStrobe <= wr;
    ioReadStrobe <= !wr;
    repeat (4) @(posedge clk);
    ioWriteStrobe <= 1'b0;
    ioReadStrobe <= 1'b0;
    repeat (4) @(posedge clk);
    chipSelect <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] idx, input logic [7:0] m, input logic [7:0] v);
    rdQ.push_back({m, v});
    cyc(1'b0, idx, 8'h00);
  endtask
  task automatic prog(input int ch, input logic [15:0] ad, input logic [15:0] n,
    input logic [5:0] md);
    cyc(1'b1, 4'hc, 8'h00);
    cyc(1'b1, 4'(2 * ch), ad[7:0]);
    cyc(1'b1, 4'(2 * ch), ad[15:8]);
    cyc(1'b1, 4'(2 * ch + 1), n[7:0]);
    cyc(1'b1, 4'(2 * ch + 1), n[15:8]);
    cyc(1'b1, 4'hb, {md, 2'(ch)});
    cyc(1'b1, 4'ha, {6'h00, 2'(ch)});
  endtask
  task automatic run(input int ch, input bit keep);
    int k;
    periphRequest[ch] <= 1'b1;
    k = 0;
    while (channelAcknowledge[ch] !== 1'b1 && k < 400)
    begin
      @(posedge clk);
      k++;
    end
    while (keep && terminalCountOut !== 1'b1 && k < 3000)
    begin
      @(posedge clk);
      k++;
    end
    @(posedge clk);
    periphRequest[ch] <= 1'b0;
    while ((holdRequest !== 1'b0 || channelAcknowledge !== 4'h0) && k < 6000)
    begin
      @(posedge clk);
      k++;
    end
    check("handshake time", 16'(k < 6000), 16'h0001);
    repeat (20) @(posedge clk);
  endtask
  initial
  begin
    fail_count = 0;
    comparisons = 0;
    tcSeen = 0;
    cascCmd = 0;
    resetn = 1'b0;
    slow = 1'b0;
    chipSelect = 1'b0;
    ioReadStrobe = 1'b0;
    ioWriteStrobe = 1'b0;
    periphRequest = 4'h0;
    regAddr = 5'h00;
    dataIn = 8'h00;
    void'($urandom(32'haa3e));
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    a = {8'h12, 8'($urandom)};
    prog(0, a, 16'h0001, 6'b010010);
    cyc(1'b1, 4'hc, 8'h00);
    rd(4'h0, 8'hff, a[7:0]);
    rd(4'h0, 8'hff, a[15:8]);
    addrQ.push_back(a);
    addrQ.push_back(a + 16'h0001);
    slow <= 1'b1;
    run(0, 1'b1);
    slow <= 1'b0;
    prog(1, 16'h3480, 16'h0002, 6'b101001);
    addrQ.push_back(16'h3480);
    run(1, 1'b0);
    slow <= 1'b1;
    prog(2, 16'h5010, 16'h0000, 6'b000100);
    addrQ.push_back(16'h5010);
    run(2, 1'b0);
    prog(3, 16'h0000, 16'h0000, 6'b110000);
    run(3, 1'b0);
    rd(4'hf, 8'h0f, 8'h03);
    rd(4'h8, 8'hff, 8'h07);
    addrQ.push_back(16'h5010);
    cyc(1'b1, 4'h9, 8'h06);
    repeat (100) @(posedge clk);
    rd(4'h8, 8'hff, 8'h04);
    rd(4'hc, 8'h00, 8'h00);
    a = a + 16'h0002;
    rd(4'h0, 8'hff, a[15:8]);
    cyc(1'b1, 4'hd, 8'h00);
    rd(4'hf, 8'hff, 8'h0f);
    repeat (4) @(posedge clk);
    check("terminal counts", 16'(tcSeen), 16'h0004);
    check("cascade commands", 16'(cascCmd), 16'h0000);
    check("strobes left", 16'(addrQ.size()), 16'h0000);
    summarize();
  end
  initial
  begin
    #(8 * 60000);
    fail_count++;
    summarize();
  end
endmodule
`default_nettype wire
